// *** hdl/spc_port.sv ***
// serial control port with configuration, identifier and readback registers

// What this block does
// - only 16-bit instructions; length bit defaults to 1, host keeps it 1.
// - soft reset bit holds the other registers at defaults until host writes it to 0.
// - bit-order 0 means msb first, address down; 1 means lsb first, up.
// - output select 0: data pin reads and writes, output pin released.
// - output select 1: reads on output pin, data pin only receives.
// - read-only 8-bit variant identifier; writes to it do nothing.
// - readback select 0 returns buffer registers, 1 returns active ones.
module spc_port #(
  parameter logic [7:0] VARIANT_ID = 8'h5a // arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst,
  input spc_pkg::spc_pins_in_t pins_in,
  output spc_pkg::spc_pins_out_t pins_out,
  output spc_pkg::spc_active_t active_cfg,
  output logic output_pin_select,
  output logic lsb_first,
  output logic soft_reset
);
  import spc_pkg::*;

  // serial engine state
  spc_state_t state_reg, state_next;
  logic sclk_prev_reg, sclk_prev_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [12:0] addr_reg, addr_next;
  logic rw_reg, rw_next;
  logic stream_reg, stream_next;
  logic [1:0] bytes_left_reg, bytes_left_next;
  logic [7:0] rd_byte_reg, rd_byte_next;
  logic out_bit_reg, out_bit_next;
  logic drive_reg, drive_next;

  // configuration state held in this module
  logic [7:0] port_cfg_reg, port_cfg_next;
  logic [7:0] readback_reg, readback_next;

  // strobes toward the register storage
  logic wr_en;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  logic [12:0] rd_addr;
  logic [7:0] bank_rd_data;
  logic bank_rd_hit;
  logic [7:0] rd_data;

  // clock edges seen through the sampled pin
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] shifted;
  logic [15:0] instr;
  logic [12:0] addr_step;

  // decoded configuration bits, low nibble used as it is mirrored above
  logic cfg_lsb_first;
  logic cfg_out_sel;
  logic cfg_soft_rst;

  assign cfg_lsb_first = port_cfg_reg[SPC_CFG_LSB_FIRST_BIT];
  assign cfg_out_sel = port_cfg_reg[SPC_CFG_OUT_SEL_BIT];
  assign cfg_soft_rst = port_cfg_reg[SPC_CFG_SOFT_RST_BIT];

  // edge detection on the serial clock
  assign sclk_rise = pins_in.sclk & ~sclk_prev_reg;
  assign sclk_fall = ~pins_in.sclk & sclk_prev_reg;
  assign shifted = {shift_reg[14:0], pins_in.sdio_in};

  // instruction word in msb order whatever the wire order
  assign instr = cfg_lsb_first ? spc_rev16(shifted) : shifted;

  // next address of a multi-byte transfer
  assign addr_step = cfg_lsb_first ? addr_reg + 13'h0001 : addr_reg - 13'h0001;

  // serial protocol: instruction, then data bytes
  always_comb begin
    state_next = state_reg;
    sclk_prev_next = pins_in.sclk;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    stream_next = stream_reg;
    bytes_left_next = bytes_left_reg;
    rd_byte_next = rd_byte_reg;
    out_bit_next = out_bit_reg;
    drive_next = drive_reg;
    wr_en = 1'b0;
    wr_addr = addr_reg;
    wr_data = 8'h00;
    rd_addr = addr_reg;
    if (pins_in.cs_n) begin
      // deselect ends any transfer and releases the pins
      state_next = SPC_ST_IDLE;
      bit_cnt_next = 4'h0;
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        SPC_ST_IDLE: begin
          state_next = SPC_ST_INSTR;
          bit_cnt_next = 4'h0;
          if (sclk_rise) begin
            shift_next = shifted;
            bit_cnt_next = 4'h1;
          end
        end
        SPC_ST_INSTR: begin
          if (sclk_rise) begin
            shift_next = shifted;
            bit_cnt_next = bit_cnt_reg + 4'h1;
            // always sixteen instruction bits, the length bit is not obeyed
            if (bit_cnt_reg == SPC_INSTR_LAST_BIT) begin
              state_next = SPC_ST_DATA;
              bit_cnt_next = 4'h0;
              rw_next = instr[SPC_INSTR_RW_BIT];
              stream_next = instr[SPC_INSTR_LEN_HI:SPC_INSTR_LEN_LO] == SPC_LEN_STREAM;
              bytes_left_next = instr[SPC_INSTR_LEN_HI:SPC_INSTR_LEN_LO];
              addr_next = instr[12:0];
              rd_addr = instr[12:0];
              rd_byte_next = rd_data;
            end
          end
        end
        SPC_ST_DATA: begin
          if (sclk_rise) begin
            shift_next = shifted;
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == SPC_BYTE_LAST_BIT) begin
              bit_cnt_next = 4'h0;
              // completed byte is written in msb order
              if (!rw_reg) begin
                wr_en = 1'b1;
                wr_data = cfg_lsb_first ? spc_rev8(shifted[7:0]) : shifted[7:0];
              end
              addr_next = addr_step;
              rd_addr = addr_step;
              rd_byte_next = rd_data;
              if (!stream_reg) begin
                if (bytes_left_reg == 2'h0) begin
                  state_next = SPC_ST_DONE;
                  drive_next = 1'b0;
                end else begin
                  bytes_left_next = bytes_left_reg - 2'h1;
                end
              end
            end
          end else if (sclk_fall && rw_reg) begin
            // read data changes on the falling edge
            drive_next = 1'b1;
            out_bit_next = cfg_lsb_first ? rd_byte_reg[bit_cnt_reg[2:0]]
                                         : rd_byte_reg[3'h7 - bit_cnt_reg[2:0]];
          end
        end
        SPC_ST_DONE: begin
          drive_next = 1'b0;
        end
        default: begin
          state_next = SPC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= SPC_ST_IDLE;
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 16'h0000;
      addr_reg <= 13'h0000;
      rw_reg <= 1'b0;
      stream_reg <= 1'b0;
      bytes_left_reg <= 2'h0;
      rd_byte_reg <= 8'h00;
      out_bit_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sclk_prev_reg <= sclk_prev_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      stream_reg <= stream_next;
      bytes_left_reg <= bytes_left_next;
      rd_byte_reg <= rd_byte_next;
      out_bit_reg <= out_bit_next;
      drive_reg <= drive_next;
    end
  end

  // port configuration and readback select registers
  always_comb begin
    port_cfg_next = port_cfg_reg;
    readback_next = readback_reg;
    if (wr_en) begin
      case (wr_addr)
        SPC_ADDR_PORT_CFG: port_cfg_next = wr_data;
        SPC_ADDR_READBACK: readback_next = wr_data & 8'h01;
        default: ; // identifier and unmapped writes dropped
      endcase
    end
    // soft reset returns the other registers to defaults
    if (cfg_soft_rst) begin
      readback_next = SPC_RST_READBACK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_cfg_reg <= SPC_RST_PORT_CFG;
      readback_reg <= SPC_RST_READBACK;
    end else begin
      port_cfg_reg <= port_cfg_next;
      readback_reg <= readback_next;
    end
  end

  // read mux across local registers and the bank
  always_comb begin
    case (rd_addr)
      SPC_ADDR_PORT_CFG: rd_data = port_cfg_reg;
      SPC_ADDR_VARIANT_ID: rd_data = VARIANT_ID;
      SPC_ADDR_READBACK: rd_data = readback_reg;
      default: rd_data = bank_rd_hit ? bank_rd_data : SPC_RST_ZERO;
    endcase
  end

  // buffered register storage
  spc_reg_bank u_bank (
    .core_clk(core_clk),
    .rst(rst),
    .soft_rst(cfg_soft_rst),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .readback_active(readback_reg[SPC_READBACK_ACTIVE_BIT]),
    .rd_data(bank_rd_data),
    .rd_hit(bank_rd_hit),
    .active(active_cfg)
  );

  // pin direction control
  spc_pin_drive u_pins (
    .out_sel(cfg_out_sel),
    .drive(drive_reg),
    .out_bit(out_bit_reg),
    .pins_out(pins_out)
  );

  // configuration state made visible to the rest of the device
  assign output_pin_select = cfg_out_sel;
  assign lsb_first = cfg_lsb_first;
  assign soft_reset = cfg_soft_rst;

endmodule

// *** pkg/spc_pkg.sv ***
// constants, types and helpers shared by the serial port configuration bank
package spc_pkg;

  // register addresses on the 13-bit serial address space
  localparam logic [12:0] SPC_ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] SPC_ADDR_VARIANT_ID = 13'h0003;
  localparam logic [12:0] SPC_ADDR_READBACK = 13'h0004;
  localparam logic [12:0] SPC_ADDR_OSC_DIV = 13'h01e0;
  localparam logic [12:0] SPC_ADDR_IN_CLK = 13'h01e1;
  localparam logic [12:0] SPC_ADDR_PD_SYNC = 13'h0230;
  localparam logic [12:0] SPC_ADDR_RSVD_SYS = 13'h0231;
  localparam logic [12:0] SPC_ADDR_UPDATE = 13'h0232;

  // values after reset
  localparam logic [7:0] SPC_RST_PORT_CFG = 8'h18;
  localparam logic [7:0] SPC_RST_READBACK = 8'h00;
  localparam logic [7:0] SPC_RST_OSC_DIV = 8'h02;
  localparam logic [7:0] SPC_RST_IN_CLK = 8'h00;
  localparam logic [7:0] SPC_RST_PD_SYNC = 8'h00;
  localparam logic [7:0] SPC_RST_ZERO = 8'h00;

  // field positions
  localparam int SPC_CFG_OUT_SEL_BIT = 0;
  localparam int SPC_CFG_LSB_FIRST_BIT = 1;
  localparam int SPC_CFG_SOFT_RST_BIT = 2;
  localparam int SPC_CFG_LONG_INSTR_BIT = 3;
  localparam int SPC_READBACK_ACTIVE_BIT = 0;
  localparam int SPC_UPDATE_ALL_BIT = 0;
  localparam int SPC_INSTR_RW_BIT = 15;
  localparam int SPC_INSTR_LEN_HI = 14;
  localparam int SPC_INSTR_LEN_LO = 13;

  // serial bit counts
  localparam logic [3:0] SPC_INSTR_LAST_BIT = 4'hf;
  localparam logic [3:0] SPC_BYTE_LAST_BIT = 4'h7;
  localparam logic [1:0] SPC_LEN_STREAM = 2'h3;

  typedef enum logic [1:0] {SPC_ST_IDLE, SPC_ST_INSTR, SPC_ST_DATA, SPC_ST_DONE} spc_state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio_in;
  } spc_pins_in_t;

  typedef struct packed {
    logic sdio_out;
    logic sdio_oe;
    logic serial_out_pin;
    logic serial_out_oe;
  } spc_pins_out_t;

  typedef struct packed {
    logic [7:0] osc_div;
    logic [7:0] in_clk;
    logic [7:0] pd_sync;
  } spc_active_t;

  // bit reversal for lsb-first transfers
  function automatic logic [15:0] spc_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  function automatic logic [7:0] spc_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

endpackage

// *** hdl/spc_reg_bank.sv ***
// buffered and active copies of the clock and power-down registers, plus the single update register
module spc_reg_bank (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wr_en,
  input wire logic [12:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [12:0] rd_addr,
  input wire logic readback_active,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output spc_pkg::spc_active_t active
);
  import spc_pkg::*;

  spc_active_t buf_reg, buf_next, act_reg, act_next;
  logic update_reg, update_next;

  // buffer writes, update-all transfer and soft reset
  always_comb begin
    buf_next = buf_reg;
    act_next = act_reg;
    update_next = 1'b0; // self-clears one cycle after being set
    if (update_reg) begin
      act_next = buf_reg;
    end
    if (wr_en) begin
      case (wr_addr)
        SPC_ADDR_OSC_DIV: buf_next.osc_div = wr_data;
        SPC_ADDR_IN_CLK: buf_next.in_clk = wr_data;
        SPC_ADDR_PD_SYNC: buf_next.pd_sync = wr_data;
        SPC_ADDR_UPDATE: update_next = wr_data[SPC_UPDATE_ALL_BIT];
        default: ;
      endcase
    end
    if (soft_rst) begin
      buf_next = '{SPC_RST_OSC_DIV, SPC_RST_IN_CLK, SPC_RST_PD_SYNC};
      act_next = '{SPC_RST_OSC_DIV, SPC_RST_IN_CLK, SPC_RST_PD_SYNC};
      update_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_reg <= '{SPC_RST_OSC_DIV, SPC_RST_IN_CLK, SPC_RST_PD_SYNC};
      act_reg <= '{SPC_RST_OSC_DIV, SPC_RST_IN_CLK, SPC_RST_PD_SYNC};
      update_reg <= 1'b0;
    end else begin
      buf_reg <= buf_next;
      act_reg <= act_next;
      update_reg <= update_next;
    end
  end

  // readback picks buffer or active bank
  always_comb begin
    spc_active_t src;
    src = readback_active ? act_reg : buf_reg;
    rd_hit = 1'b1;
    case (rd_addr)
      SPC_ADDR_OSC_DIV: rd_data = src.osc_div;
      SPC_ADDR_IN_CLK: rd_data = src.in_clk;
      SPC_ADDR_PD_SYNC: rd_data = src.pd_sync;
      SPC_ADDR_RSVD_SYS: rd_data = SPC_RST_ZERO;
      SPC_ADDR_UPDATE: rd_data = {7'h00, update_reg};
      default: begin
        rd_data = SPC_RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign active = act_reg;

endmodule

// *** hdl/spc_pin_drive.sv ***
// steers read data onto the shared data pin or the dedicated output pin
module spc_pin_drive (
  input wire logic out_sel,
  input wire logic drive,
  input wire logic out_bit,
  output spc_pkg::spc_pins_out_t pins_out
);
  import spc_pkg::*;

  // one pin drives read data, the other stays released
  always_comb begin
    pins_out.sdio_out = out_bit;
    pins_out.serial_out_pin = out_bit;
    pins_out.sdio_oe = drive & ~out_sel;
    pins_out.serial_out_oe = drive & out_sel;
  end

endmodule

// *** verification/spc_host_model.sv ***
// host controller model that drives the serial control port pins
module spc_host_model (
  input wire logic core_clk,
  output spc_pkg::spc_pins_in_t pins_in,
  input spc_pkg::spc_pins_out_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  logic lsb = 1'b0;
  logic sel = 1'b0;

  // idle: deselected, serial clock parked low
  initial begin
    pins_in = '{sclk: 1'b0, cs_n: 1'b1, sdio_in: 1'b0};
  end

  // one serial bit: data set while low, taken at rise, read bit picked late in the low phase
  task automatic bit_io(input logic d, output logic q);
    pins_in.sclk <= 1'b0;
    pins_in.sdio_in <= d;
    repeat (4) @(posedge core_clk);
    q = sel ? pins_out.serial_out_pin : pins_out.sdio_out;
    pins_in.sclk <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // whole frame: 16-bit instruction then len+1 bytes, data left-justified in wd and q
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] a,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [15:0] ins;
    logic b;
    int j;
    ins = {rd, len, a};
    q = 16'h0000;
    b = 1'b0;
    @(posedge core_clk);
    pins_in.cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) bit_io(lsb ? ins[i] : ins[15 - i], b);
    for (int k = 0; k <= len; k++) begin
      for (int i = 0; i < 8; i++) begin
        j = 15 - 8 * k - (lsb ? 7 - i : i);
        bit_io(rd ? ~b : wd[j], b); // released line shows a changing level
        q[j] = b;
      end
    end
    pins_in.cs_n <= 1'b1;
    pins_in.sclk <= 1'b0;
    repeat (4) @(posedge core_clk);
    if (!rd && a == SPC_ADDR_PORT_CFG) {lsb, sel} = wd[9:8];
  endtask

  // port configuration write, f = {soft reset, lsb first, output select}
  task automatic set_cfg(input logic [2:0] f);
    logic [3:0] n;
    logic [15:0] q;
    n = {1'b1, f};
    xfer(1'b0, 2'h0, SPC_ADDR_PORT_CFG, {n[0], n[1], n[2], n[3], n, 8'h00}, q);
  endtask
endmodule

// *** verification/spc_port_sva.sv ***
// assertions on the serial configuration port outputs
module spc_port_sva (
  input wire logic core_clk,
  input wire logic rst,
  input spc_pkg::spc_pins_in_t pins_in,
  input spc_pkg::spc_pins_out_t pins_out,
  input spc_pkg::spc_active_t active_cfg,
  input wire logic output_pin_select,
  input wire logic lsb_first,
  input wire logic soft_reset
);
  import spc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // frame gap and held soft reset
  sequence s_idle;
    pins_in.cs_n [*4];
  endsequence
  sequence s_srst;
    soft_reset [*3];
  endsequence

  property p_oe_excl;
    !(pins_out.sdio_oe && pins_out.serial_out_oe);
  endproperty
  property p_sdo_hiz;
    !output_pin_select |-> !pins_out.serial_out_oe;
  endproperty
  property p_sdio_rx;
    output_pin_select |-> !pins_out.sdio_oe;
  endproperty
  property p_idle_oe;
    s_idle |-> !pins_out.sdio_oe && !pins_out.serial_out_oe;
  endproperty
  property p_rst_dflt;
    $fell(rst) |-> !lsb_first && !output_pin_select && !soft_reset &&
      active_cfg == {SPC_RST_OSC_DIV, SPC_RST_IN_CLK, SPC_RST_PD_SYNC};
  endproperty
  property p_srst;
    s_srst |-> active_cfg == {SPC_RST_OSC_DIV, SPC_RST_IN_CLK, SPC_RST_PD_SYNC};
  endproperty
  property p_act_hold;
    s_idle |-> $stable(active_cfg);
  endproperty
  property p_cfg_hold;
    s_idle |-> $stable({output_pin_select, lsb_first, soft_reset});
  endproperty
  property p_out_fall;
    $changed(pins_out.serial_out_pin) |-> !$past(pins_in.sclk);
  endproperty

  a_oe_excl: assert property (p_oe_excl) else $error("both data pins driven");
  a_sdo_hiz: assert property (p_sdo_hiz) else $error("output pin driven in shared mode");
  a_sdio_rx: assert property (p_sdio_rx) else $error("data pin driven in split mode");
  a_idle_oe: assert property (p_idle_oe) else $error("pin driven while deselected");
  a_rst_dflt: assert property (p_rst_dflt) else $error("wrong values after reset");
  a_srst: assert property (p_srst) else $error("bank not at defaults in soft reset");
  a_act_hold: assert property (p_act_hold) else $error("active bank moved while idle");
  a_cfg_hold: assert property (p_cfg_hold) else $error("port mode moved while idle");
  a_out_fall: assert property (p_out_fall) else $error("read bit moved outside low phase");
endmodule

bind spc_port spc_port_sva u_sva (.core_clk(core_clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out),
  .active_cfg(active_cfg), .output_pin_select(output_pin_select), .lsb_first(lsb_first),
  .soft_reset(soft_reset));

// *** verification/spc_port_tb.sv ***
// self-checking bench for the serial port configuration bank
module spc_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  localparam logic [7:0] ID = 8'ha7; // arbitrary value
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  spc_pins_in_t pins_in;
  spc_pins_out_t pins_out;
  spc_active_t active_cfg;
  logic output_pin_select;
  logic lsb_first;
  logic soft_reset;
  logic [15:0] q;
  int miscompares = 0;
  int checks_done = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  spc_port #(.VARIANT_ID(ID)) dut (.core_clk(core_clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out),
    .active_cfg(active_cfg), .output_pin_select(output_pin_select), .lsb_first(lsb_first),
    .soft_reset(soft_reset));
  spc_host_model host (.core_clk(core_clk), .pins_in(pins_in), .pins_out(pins_out));

  // comparison, verdict and access helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, 2'h0, a, {d, 8'h00}, q);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e, input string n);
    host.xfer(1'b1, 2'h0, a, 16'h0000, q);
    chk(n, {8'h00, e}, {8'h00, q[15:8]});
  endtask

  // watchdog
  initial begin
    #300us;
    miscompares++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(SPC_ADDR_PORT_CFG, SPC_RST_PORT_CFG, "port cfg");
    rd(SPC_ADDR_VARIANT_ID, ID, "identifier");
    wr(SPC_ADDR_VARIANT_ID, 8'hff);
    rd(SPC_ADDR_VARIANT_ID, ID, "identifier after write");
    wr(SPC_ADDR_RSVD_SYS, 8'hff);
    rd(SPC_ADDR_RSVD_SYS, 8'h00, "reserved");
    rd(13'h0100, 8'h00, "unmapped");
    host.xfer(1'b0, 2'h1, SPC_ADDR_IN_CLK, 16'h0307, q);
    wr(SPC_ADDR_PD_SYNC, 8'h05);
    rd(SPC_ADDR_PD_SYNC, 8'h05, "buffered power-down");
    chk("active power-down", 16'h0000, {8'h00, active_cfg.pd_sync});
    rd(SPC_ADDR_OSC_DIV, 8'h07, "buffered divider");
    chk("active divider", 16'h0002, {8'h00, active_cfg.osc_div});
    wr(SPC_ADDR_READBACK, 8'h01);
    rd(SPC_ADDR_OSC_DIV, 8'h02, "active readback");
    wr(SPC_ADDR_UPDATE, 8'h01);
    chk("active after update", 16'h0307, {active_cfg.in_clk, active_cfg.osc_div});
    chk("active power-down after update", 16'h0005, {8'h00, active_cfg.pd_sync});
    rd(SPC_ADDR_UPDATE, 8'h00, "update flag");
    rd(SPC_ADDR_OSC_DIV, 8'h07, "active readback");
    host.set_cfg(3'b010);
    chk("lsb first", 16'h0001, {15'h0000, lsb_first});
    host.xfer(1'b1, 2'h1, SPC_ADDR_OSC_DIV, 16'h0000, q);
    chk("rising address read", 16'h0703, q);
    host.set_cfg(3'b001);
    chk("pin select", 16'h0001, {15'h0000, output_pin_select});
    rd(SPC_ADDR_VARIANT_ID, ID, "identifier on output pin");
    host.set_cfg(3'b100);
    chk("soft reset", 16'h0001, {15'h0000, soft_reset});
    chk("divider in soft reset", 16'h0002, {8'h00, active_cfg.osc_div});
    chk("power-down in soft reset", 16'h0000, {8'h00, active_cfg.pd_sync});
    rd(SPC_ADDR_READBACK, SPC_RST_READBACK, "readback select");
    rd(SPC_ADDR_OSC_DIV, SPC_RST_OSC_DIV, "divider default");
    host.set_cfg(3'b000);
    chk("soft reset clear", 16'h0000, {15'h0000, soft_reset});
    wr(SPC_ADDR_OSC_DIV, 8'h09);
    rd(SPC_ADDR_OSC_DIV, 8'h09, "divider after soft reset");
    tally_and_finish();
  end
endmodule
